// ==== verilog/rco_pkg.sv ====
/*
  Constants for the oscillator clock control block: register map, field
  positions, reset values, oscillator rates and derived cycle counts.
  Assumes a single reference clock of 250 MHz that times both RC oscillators.
*/
package rco_pkg;

  // Reference clock and oscillator rates in Hz
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned LS_LOW_HZ = 25000;
  localparam int unsigned LS_HIGH_HZ = 2000000;
  localparam int unsigned FAST_HZ = 25000000;

  // Half periods in reference cycles, rounded down, never below one
  localparam int unsigned LS_LOW_HALF = CLK_HZ / (2 * LS_LOW_HZ);
  localparam int unsigned LS_HIGH_HALF = CLK_HZ / (2 * LS_HIGH_HZ);
  localparam int unsigned FAST_HALF = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned HALF_W = 16;

  // Cycles spent clearing dividers during the start-up sequence
  localparam logic [3:0] INIT_CYCLES = 4'h4;

  // Register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W = 16;
  localparam logic [7:0] REG_LS_CFG = 8'h00;
  localparam logic [7:0] REG_FAST_CFG = 8'h04;
  localparam logic [7:0] REG_XTAL_CFG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Low-speed configuration fields
  localparam int unsigned LS_RANGE_BIT = 0;
  localparam int unsigned LS_PREDIV_LSB = 1;
  localparam int unsigned LS_SEL_A_LSB = 3;
  localparam int unsigned LS_SEL_B_LSB = 6;
  localparam int unsigned LS_POL_BIT = 9;
  localparam int unsigned LS_MODE_BIT = 10;
  localparam int unsigned LS_QUICK_BIT = 11;
  localparam int unsigned LS_SRC_LSB = 12;

  // Fast configuration fields
  localparam int unsigned FAST_PREDIV_LSB = 0;
  localparam int unsigned FAST_POL_BIT = 2;
  localparam int unsigned FAST_MODE_BIT = 3;
  localparam int unsigned FAST_SRC_BIT = 4;

  // Crystal configuration fields
  localparam int unsigned XTAL_FORCE_BIT = 0;

  // Low-speed source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_PIN_A = 2'h1;
  localparam logic [1:0] SRC_PIN_B = 2'h2;

  // Second-stage tap code that selects nothing
  localparam logic [2:0] TAP_OFF = 3'h7;

  typedef enum logic [1:0] {
    RCO_IDLE,
    RCO_CLEAR,
    RCO_READY
  } rco_init_t;

endpackage

// ==== verilog/rco_clock_ctrl.sv ====
/*
  Clock control for a low-speed RC oscillator (two ranges), a fast RC
  oscillator and a crystal path, each with request logic; the two RC paths
  also have pre-divider and power control, and the low-speed path has a
  two-output second divider.
  Assumes ref_clk at 250 MHz times the modelled oscillators, pins arrive
  asynchronously, and requests come from logic on ref_clk.
*/
// Design decisions made here: the address map and the address-and-strobe port.
module rco_clock_ctrl #(
  parameter int unsigned LS_LOW_HALF_CYCLES = rco_pkg::LS_LOW_HALF,
  parameter int unsigned LS_HIGH_HALF_CYCLES = rco_pkg::LS_HIGH_HALF,
  parameter int unsigned FAST_HALF_CYCLES = rco_pkg::FAST_HALF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [rco_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rco_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rco_pkg::DATA_W-1:0] reg_rdata,
  input wire logic init_request,
  output logic osc_init_done,
  input wire logic oscillator_power_input_ls,
  input wire logic oscillator_power_input_fast,
  input wire logic slow_clock_input_pin_a,
  input wire logic slow_clock_input_pin_b,
  input wire logic crystal_input_pin,
  input wire logic ls_delay_request,
  input wire logic ls_counter_state_machine_request,
  input wire logic fast_delay_request,
  input wire logic fast_counter_state_machine_request,
  input wire logic xtal_delay_request,
  input wire logic xtal_counter_state_machine_request,
  output logic ls_prediv_clk,
  output logic divided_clock_a,
  output logic divided_clock_b,
  output logic fast_prediv_clk,
  output logic crystal_clk,
  output logic ls_running,
  output logic fast_running,
  output logic crystal_running
);

  // Refuse half periods the counters cannot hold
  if (LS_LOW_HALF_CYCLES < 1 || LS_LOW_HALF_CYCLES > 65535 ||
      LS_HIGH_HALF_CYCLES < 1 || LS_HIGH_HALF_CYCLES > 65535 ||
      FAST_HALF_CYCLES < 1 || FAST_HALF_CYCLES > 65535) begin : g_bad_half
    $error("rco_clock_ctrl: half period out of range");
  end

  // Divider tap: zero picks the input level, seven picks nothing, otherwise a counter bit
  function automatic logic rco_tap(input logic lvl, input logic [5:0] cnt, input logic [2:0] sel);
    logic res;
    res = 1'b0;
    if (sel == 3'h0) begin
      res = lvl;
    end else if (sel != rco_pkg::TAP_OFF) begin
      res = cnt[sel - 3'h1];
    end
    return res;
  endfunction

  localparam logic [15:0] LS_LOW_RELOAD = 16'(LS_LOW_HALF_CYCLES - 1);
  localparam logic [15:0] LS_HIGH_RELOAD = 16'(LS_HIGH_HALF_CYCLES - 1);
  localparam logic [15:0] FAST_RELOAD = 16'(FAST_HALF_CYCLES - 1);

  logic [15:0] ls_cfg_reg;
  logic [15:0] fast_cfg_reg;
  logic [15:0] xtal_cfg_reg;
  logic [rco_pkg::DATA_W-1:0] rdata_reg;
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  rco_pkg::rco_init_t init_state_reg;
  logic [3:0] init_cnt_reg;
  logic ready;
  logic ls_pwr_ok, fast_pwr_ok;
  logic ls_run, fast_run, xtal_run;
  logic [15:0] ls_half_cnt_reg, fast_half_cnt_reg;
  logic ls_osc_reg, fast_osc_reg;
  logic ls_src_raw, fast_src_raw, xtal_src_raw;
  logic ls_arm_reg, fast_arm_reg, xtal_arm_reg;
  logic ls_fund, fast_fund;
  logic ls_fund_d_reg, fast_fund_d_reg;
  logic [2:0] ls_pre_cnt_reg, fast_pre_cnt_reg;
  logic ls_pre_lvl, fast_pre_lvl;
  logic ls_pre_d_reg;
  logic [5:0] ls_sec_cnt_reg;
  logic ls_pre_out_reg, out_a_reg, out_b_reg, fast_pre_out_reg, xtal_out_reg;

  // Register writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ls_cfg_reg <= rco_pkg::CFG_RESET;
      fast_cfg_reg <= rco_pkg::CFG_RESET;
      xtal_cfg_reg <= rco_pkg::CFG_RESET;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        rco_pkg::REG_LS_CFG: ls_cfg_reg <= reg_wdata[15:0];
        rco_pkg::REG_FAST_CFG: fast_cfg_reg <= reg_wdata[15:0];
        rco_pkg::REG_XTAL_CFG: xtal_cfg_reg <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0;
    end else if (clk_en) begin
      rdata_reg <= 32'h0;
      if (reg_rd) begin
        unique case (reg_addr)
          rco_pkg::REG_LS_CFG: rdata_reg <= {16'h0, ls_cfg_reg};
          rco_pkg::REG_FAST_CFG: rdata_reg <= {16'h0, fast_cfg_reg};
          rco_pkg::REG_XTAL_CFG: rdata_reg <= {16'h0, xtal_cfg_reg};
          rco_pkg::REG_STATUS: rdata_reg <= {26'h0, pin_sync_reg[1:0], xtal_run, fast_run, ls_run, ready};
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_reg;

  // Two-stage synchronisers for all pins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 5'h0;
      pin_sync_reg <= 5'h0;
    end else if (clk_en) begin
      pin_meta_reg <= {crystal_input_pin, slow_clock_input_pin_b, slow_clock_input_pin_a,
                       oscillator_power_input_fast, oscillator_power_input_ls};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Start-up: clear the oscillator logic, then report it ready
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_state_reg <= rco_pkg::RCO_IDLE;
      init_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      unique case (init_state_reg)
        rco_pkg::RCO_IDLE: begin
          init_cnt_reg <= 4'h0;
          if (init_request) begin
            init_state_reg <= rco_pkg::RCO_CLEAR;
          end
        end
        rco_pkg::RCO_CLEAR: begin
          init_cnt_reg <= init_cnt_reg + 4'h1;
          if (init_cnt_reg == rco_pkg::INIT_CYCLES - 4'h1) begin
            init_state_reg <= rco_pkg::RCO_READY;
          end
        end
        rco_pkg::RCO_READY: begin
          if (!init_request) begin
            init_state_reg <= rco_pkg::RCO_IDLE;
          end
        end
        // The unused fourth code falls back to idle
        default: init_state_reg <= rco_pkg::RCO_IDLE;
      endcase
    end
  end
  assign ready = (init_state_reg == rco_pkg::RCO_READY);
  assign osc_init_done = ready;

  // Enables: the power input gates the low-speed and fast requests, the crystal path has none; each path independent
  assign ls_pwr_ok = ls_cfg_reg[rco_pkg::LS_POL_BIT] ? pin_sync_reg[0] : ~pin_sync_reg[0];
  assign fast_pwr_ok = fast_cfg_reg[rco_pkg::FAST_POL_BIT] ? pin_sync_reg[1] : ~pin_sync_reg[1];
  assign ls_run = ready & ls_pwr_ok & (ls_cfg_reg[rco_pkg::LS_MODE_BIT] | ls_cfg_reg[rco_pkg::LS_QUICK_BIT] |
                  ls_delay_request | ls_counter_state_machine_request);
  assign fast_run = ready & fast_pwr_ok & (fast_cfg_reg[rco_pkg::FAST_MODE_BIT] | fast_delay_request |
                    fast_counter_state_machine_request);
  assign xtal_run = ready & (xtal_cfg_reg[rco_pkg::XTAL_FORCE_BIT] | xtal_delay_request |
                    xtal_counter_state_machine_request);
  assign ls_running = ls_run;
  assign fast_running = fast_run;
  assign crystal_running = xtal_run;

  // Low-speed RC oscillator, range picks the half period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ls_half_cnt_reg <= 16'h0;
      ls_osc_reg <= 1'b0;
    end else if (clk_en) begin
      if (!ls_run) begin
        ls_half_cnt_reg <= 16'h0;
        ls_osc_reg <= 1'b0;
      end else if (ls_half_cnt_reg == 16'h0) begin
        ls_half_cnt_reg <= ls_cfg_reg[rco_pkg::LS_RANGE_BIT] ? LS_HIGH_RELOAD : LS_LOW_RELOAD;
        ls_osc_reg <= ~ls_osc_reg;
      end else begin
        ls_half_cnt_reg <= ls_half_cnt_reg - 16'h1;
      end
    end
  end

  // Fast RC oscillator
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fast_half_cnt_reg <= 16'h0;
      fast_osc_reg <= 1'b0;
    end else if (clk_en) begin
      if (!fast_run) begin
        fast_half_cnt_reg <= 16'h0;
        fast_osc_reg <= 1'b0;
      end else if (fast_half_cnt_reg == 16'h0) begin
        fast_half_cnt_reg <= FAST_RELOAD;
        fast_osc_reg <= ~fast_osc_reg;
      end else begin
        fast_half_cnt_reg <= fast_half_cnt_reg - 16'h1;
      end
    end
  end

  // Fundamental source selection: internal oscillator or a pin
  always_comb begin
    unique case (ls_cfg_reg[rco_pkg::LS_SRC_LSB +: 2])
      rco_pkg::SRC_PIN_A: ls_src_raw = pin_sync_reg[2];
      rco_pkg::SRC_PIN_B: ls_src_raw = pin_sync_reg[3];
      default: ls_src_raw = ls_osc_reg;
    endcase
  end
  assign fast_src_raw = fast_cfg_reg[rco_pkg::FAST_SRC_BIT] ? pin_sync_reg[4] : fast_osc_reg;
  assign xtal_src_raw = pin_sync_reg[4];

  // Arm on a low source level so a restart never begins mid-pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ls_arm_reg <= 1'b0;
      fast_arm_reg <= 1'b0;
      xtal_arm_reg <= 1'b0;
    end else if (clk_en) begin
      ls_arm_reg <= ls_run & (ls_arm_reg | ~ls_src_raw);
      fast_arm_reg <= fast_run & (fast_arm_reg | ~fast_src_raw);
      xtal_arm_reg <= xtal_run & (xtal_arm_reg | ~xtal_src_raw);
    end
  end
  assign ls_fund = ls_arm_reg & ls_src_raw;
  assign fast_fund = fast_arm_reg & fast_src_raw;

  // Pre-dividers count fundamental rising edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ls_fund_d_reg <= 1'b0;
      fast_fund_d_reg <= 1'b0;
      ls_pre_cnt_reg <= 3'h0;
      fast_pre_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      ls_fund_d_reg <= ls_fund;
      fast_fund_d_reg <= fast_fund;
      if (!ls_run) begin
        ls_pre_cnt_reg <= 3'h0;
      end else if (ls_fund && !ls_fund_d_reg) begin
        ls_pre_cnt_reg <= ls_pre_cnt_reg + 3'h1;
      end
      if (!fast_run) begin
        fast_pre_cnt_reg <= 3'h0;
      end else if (fast_fund && !fast_fund_d_reg) begin
        fast_pre_cnt_reg <= fast_pre_cnt_reg + 3'h1;
      end
    end
  end
  assign ls_pre_lvl = rco_tap(ls_fund, {3'h0, ls_pre_cnt_reg},
                              {1'b0, ls_cfg_reg[rco_pkg::LS_PREDIV_LSB +: 2]});
  assign fast_pre_lvl = rco_tap(fast_fund, {3'h0, fast_pre_cnt_reg},
                                {1'b0, fast_cfg_reg[rco_pkg::FAST_PREDIV_LSB +: 2]});

  // Second stage on the low-speed path counts pre-divided edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ls_pre_d_reg <= 1'b0;
      ls_sec_cnt_reg <= 6'h0;
    end else if (clk_en) begin
      ls_pre_d_reg <= ls_pre_lvl;
      if (!ls_run) begin
        ls_sec_cnt_reg <= 6'h0;
      end else if (ls_pre_lvl && !ls_pre_d_reg) begin
        ls_sec_cnt_reg <= ls_sec_cnt_reg + 6'h1;
      end
    end
  end

  // Registered clock outputs, held low whenever the source is stopped; the crystal output one cycle later, through its arm register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ls_pre_out_reg <= 1'b0;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      fast_pre_out_reg <= 1'b0;
      xtal_out_reg <= 1'b0;
    end else if (clk_en) begin
      ls_pre_out_reg <= ls_run & ls_pre_lvl;
      out_a_reg <= ls_run & rco_tap(ls_pre_lvl, ls_sec_cnt_reg,
                                    ls_cfg_reg[rco_pkg::LS_SEL_A_LSB +: 3]);
      out_b_reg <= ls_run & rco_tap(ls_pre_lvl, ls_sec_cnt_reg,
                                    ls_cfg_reg[rco_pkg::LS_SEL_B_LSB +: 3]);
      fast_pre_out_reg <= fast_run & fast_pre_lvl;
      xtal_out_reg <= xtal_arm_reg & xtal_src_raw;
    end
  end
  assign ls_prediv_clk = ls_pre_out_reg;
  assign divided_clock_a = out_a_reg;
  assign divided_clock_b = out_b_reg;
  assign fast_prediv_clk = fast_pre_out_reg;
  assign crystal_clk = xtal_out_reg;

endmodule

// ==== tb/rco_macro_model.sv ====
/*
  Far-side macrocells: raise oscillator requests and count clock edges.
  Assumes it runs on ref_clk beside the clock control block.
*/
module rco_macro_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] want,
  output logic [5:0] req,
  input wire logic watch_clk,
  output int rise_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  // Requests are same-clock levels, one per user macrocell
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) req <= 6'h00;
    else req <= want;
  end
  // Counts rising edges of the watched clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      last <= 1'b0;
      rise_cnt <= 0;
    end else begin
      last <= watch_clk;
      if (watch_clk && !last) rise_cnt <= rise_cnt + 1;
    end
  end
endmodule

// ==== tb/rco_clock_ctrl_checker.sv ====
/*
  Port assertions for the clock control block.
  Assumes the default fast half period of five cycles.
*/
module rco_clock_ctrl_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic init_request,
  input wire logic osc_init_done,
  input wire logic ls_prediv_clk,
  input wire logic divided_clock_a,
  input wire logic divided_clock_b,
  input wire logic fast_prediv_clk,
  input wire logic crystal_clk,
  input wire logic ls_running,
  input wire logic fast_running,
  input wire logic crystal_running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Init is taken, then done rises after the clear cycles
  sequence s_take; $rose(init_request) && !osc_init_done && clk_en; endsequence
  sequence s_wait; !osc_init_done [*5] ##1 osc_init_done; endsequence
  property p_init_time; s_take |-> s_wait; endproperty
  property p_gate; !osc_init_done |-> !ls_running && !fast_running && !crystal_running; endproperty
  property p_ls_stop; !ls_running && clk_en |=> !ls_prediv_clk && !divided_clock_a && !divided_clock_b; endproperty
  property p_fast_stop; !fast_running && clk_en |=> !fast_prediv_clk; endproperty
  property p_xtal_stop; !crystal_running && clk_en |=> !crystal_clk; endproperty
  // A high phase that ends while running lasted the full half period
  property p_fast_pulse; $fell(fast_prediv_clk) && $past(fast_running) |-> $past(fast_prediv_clk, 5); endproperty
  property p_rd_idle; clk_en && !(reg_rd && reg_addr[7:4] == 4'h0 && reg_addr[1:0] == 2'h0) |=> reg_rdata == '0;
  endproperty
  property p_status; reg_rd && clk_en && reg_addr == rco_pkg::REG_STATUS |=> reg_rdata[31:6] == '0 &&
    reg_rdata[3:0] == {$past(crystal_running), $past(fast_running), $past(ls_running), $past(osc_init_done)};
  endproperty
  a_init_time: assert property (p_init_time) else $error("init done at wrong cycle");
  a_gate: assert property (p_gate) else $error("oscillator runs before init");
  a_ls_stop: assert property (p_ls_stop) else $error("low-speed output high while stopped");
  a_fast_stop: assert property (p_fast_stop) else $error("fast output high while stopped");
  a_xtal_stop: assert property (p_xtal_stop) else $error("crystal output high while stopped");
  a_fast_pulse: assert property (p_fast_pulse) else $error("short fast pulse");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_status: assert property (p_status) else $error("status does not match run flags");
endmodule

bind rco_clock_ctrl rco_clock_ctrl_checker u_chk (.*);

// ==== tb/rco_clock_ctrl_tb_top.sv ====
/*
  Testbench for the clock control block: register tasks and rate counts.
  Assumes short low-speed half periods set through the parameters.
*/
module rco_clock_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HH = 4;
  localparam int LH = 8;
  localparam int FH = 5;
  localparam int N = 1280;
  logic ref_clk = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, init_request = 0;
  logic pwr_ls = 0, pwr_fast = 0, pin_a = 0, pin_b = 0, xin = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [5:0] want = 6'h00, req;
  logic ls_pc, dca, dcb, fast_pc, xclk, ls_run, fast_run, x_run, done;
  logic [4:0] clks;
  int wsel = 0, cyc = 0, rise_cnt, c0, error_cnt = 0, n_tests = 0;
  assign clks = {xclk, dcb, dca, ls_pc, fast_pc};
  rco_clock_ctrl #(.LS_LOW_HALF_CYCLES(LH), .LS_HIGH_HALF_CYCLES(HH), .FAST_HALF_CYCLES(FH)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_request(init_request), .osc_init_done(done),
    .oscillator_power_input_ls(pwr_ls), .oscillator_power_input_fast(pwr_fast), .slow_clock_input_pin_a(pin_a),
    .slow_clock_input_pin_b(pin_b), .crystal_input_pin(xin), .ls_delay_request(req[0]),
    .ls_counter_state_machine_request(req[1]), .fast_delay_request(req[2]),
    .fast_counter_state_machine_request(req[3]), .xtal_delay_request(req[4]),
    .xtal_counter_state_machine_request(req[5]), .ls_prediv_clk(ls_pc), .divided_clock_a(dca),
    .divided_clock_b(dcb), .fast_prediv_clk(fast_pc), .crystal_clk(xclk), .ls_running(ls_run),
    .fast_running(fast_run), .crystal_running(x_run));
  rco_macro_model far (.ref_clk(ref_clk), .resetn(resetn), .want(want), .req(req), .watch_clk(clks[wsel]),
    .rise_cnt(rise_cnt));
  always #2 ref_clk = ~ref_clk;
  // External clocks on the pins and the run limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pin_a <= cyc[4];
    pin_b <= cyc[3];
    xin <= cyc[2];
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    tick();
    chk(nm, reg_rdata, e);
  endtask
  // Counts rises of one output over a window, one edge of slack
  task automatic meas(int w, int e, string nm);
    wsel = w;
    tick(40);
    c0 = rise_cnt;
    tick(N);
    chk(nm, {31'h0, (rise_cnt - c0 >= e - 1) && (rise_cnt - c0 <= e + 1)}, 32'h1);
  endtask
  initial begin
    tick(4);
    resetn <= 1'b1;
    tick();
    rd(rco_pkg::REG_LS_CFG, 32'h0, "ls_cfg reset");
    rd(rco_pkg::REG_FAST_CFG, 32'h0, "fast_cfg reset");
    rd(rco_pkg::REG_XTAL_CFG, 32'h0, "xtal_cfg reset");
    wr(8'h10, 32'hffff);
    rd(8'h10, 32'h0, "unmapped");
    wr(rco_pkg::REG_FAST_CFG, 32'h8);
    tick(3);
    chk("fast run before init", fast_run, 0);
    init_request <= 1'b1;
    tick(8);
    chk("init done", done, 1);
    chk("fast forced", fast_run, 1);
    chk("ls not forced", ls_run, 0);
    wr(rco_pkg::REG_LS_CFG, 32'h401);
    wr(rco_pkg::REG_XTAL_CFG, 32'h1);
    tick(3);
    rd(rco_pkg::REG_STATUS, 32'hf, "all three run");
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(rco_pkg::REG_LS_CFG, 32'h0);
    chk("frozen write", ls_run, 1);
    clk_en <= 1'b1;
    rd(rco_pkg::REG_LS_CFG, 32'h401, "write ignored while frozen");
    for (int k = 0; k < 4; k++) begin
      // Stop first so the new ratio starts without a cut pulse
      wr(rco_pkg::REG_FAST_CFG, 32'(k));
      wr(rco_pkg::REG_FAST_CFG, 32'h8 | k);
      meas(0, N / ((2 * FH) << k), "fast prediv");
    end
    pwr_fast <= 1'b1;
    pwr_ls <= 1'b1;
    tick(4);
    chk("fast power off", fast_run, 0);
    chk("fast held low", fast_pc, 0);
    chk("ls power off", ls_run, 0);
    rd(rco_pkg::REG_STATUS, 32'h39, "power inputs seen");
    pwr_ls <= 1'b0;
    wr(rco_pkg::REG_FAST_CFG, 32'hc);
    tick(3);
    chk("force-on high", fast_run, 1);
    pwr_fast <= 1'b0;
    tick(4);
    chk("force-on low", fast_run, 0);
    wr(rco_pkg::REG_FAST_CFG, 32'h0);
    wr(rco_pkg::REG_LS_CFG, 32'h1);
    wr(rco_pkg::REG_XTAL_CFG, 32'h0);
    tick(2);
    chk("auto idle", {x_run, fast_run, ls_run}, 0);
    for (int i = 0; i < 6; i++) begin
      want <= 6'h01 << i;
      tick(3);
      chk("request", {x_run, fast_run, ls_run}, 3'b001 << (i / 2));
    end
    want <= 6'h00;
    wr(rco_pkg::REG_LS_CFG, 32'h801);
    tick(2);
    chk("quick start", ls_run, 1);
    for (int k = 0; k < 7; k++) begin
      wr(rco_pkg::REG_LS_CFG, 32'h401 | (k << 3) | ((6 - k) << 6));
      meas(2, N / ((2 * HH) << k), "tap a");
      meas(3, N / ((2 * HH) << (6 - k)), "tap b");
    end
    wr(rco_pkg::REG_LS_CFG, 32'h401 | (7 << 6));
    meas(3, 0, "tap b off");
    wr(rco_pkg::REG_LS_CFG, 32'h400);
    meas(1, N / (2 * LH), "ls low range");
    wr(rco_pkg::REG_LS_CFG, 32'h1400);
    meas(1, N / 32, "pin a");
    wr(rco_pkg::REG_LS_CFG, 32'h2400);
    meas(1, N / 16, "pin b");
    wr(rco_pkg::REG_XTAL_CFG, 32'h1);
    meas(4, N / 8, "crystal pin");
    wr(rco_pkg::REG_FAST_CFG, 32'h19);
    meas(0, N / 16, "fast from pin");
    resetn <= 1'b0;
    tick(2);
    chk("reset clears done", done, 0);
    chk("reset clears clock", fast_pc, 0);
    resetn <= 1'b1;
    tick(2);
    give_verdict();
  end
endmodule
